/* src/gpir_cfg.svh */
// Purpose: Constants of the pin interrupt router
// Assumes: APB byte addresses, 32-bit data
// Notes:   Included by the design modules and the testbench
//
// What this block does
// - Rate codes 13..15 sample every 32*256, 64*256, 128*256 bus clocks.
// - Rate code n samples every 2**n bus clocks for codes 0..12.
// - Bits 3..0 enable debounce per request; clear means direct pass.
// - Two-bit field 2x+1:2x routes pin x to request 0..3.
// - Port B grouping resets to request 1 for every pin.
// - Port C grouping resets to request 2; port A to request 0.
// - Fall enable at bit x, rise enable at bit x+16 per pin.
// - Rise and fall enables may be set together for both edges.
// - Wake source pins act on level (high with rise enabled, else low with fall); that level blocks entry or wakes.
// - With both edges enabled the high level is the wake level.
// - Bit 8 picks one-clock pulse or held request until flags clear.
// - Bits 7..4 let each request wake the chip from power down.
// - Bits 3..0 let each request snapshot all three ports together.
// - Snapshot registers are read-only, bit x per pin, reset zero.
// - Trigger flags read one per source pin; writing one clears.
// - A flag latches on any enabled edge, with or without debounce.
`ifndef GPIR_CFG_SVH
`define GPIR_CFG_SVH
`define GPIR_OFF_DBC      12'h070
`define GPIR_OFF_GRP_A    12'h080
`define GPIR_OFF_GRP_B    12'h084
`define GPIR_OFF_GRP_C    12'h088
`define GPIR_OFF_EDGE_A   12'h090
`define GPIR_OFF_EDGE_B   12'h094
`define GPIR_OFF_EDGE_C   12'h098
`define GPIR_OFF_CTRL     12'h0a0
`define GPIR_OFF_SNAP_A   12'h0a4
`define GPIR_OFF_SNAP_B   12'h0a8
`define GPIR_OFF_SNAP_C   12'h0ac
`define GPIR_OFF_FLAG_AB  12'h0b4
`define GPIR_OFF_FLAG_C   12'h0b8
`define GPIR_OFF_ISTAT    12'h0c0
`define GPIR_OFF_IMASK    12'h0c4
`define GPIR_OFF_PWR      12'h0c8
`define GPIR_RST_GRP_A    32'h00000000
`define GPIR_RST_GRP_B    32'h00055555
`define GPIR_RST_GRP_C    32'h002aaaaa
`define GPIR_RISE_POS     16
`define GPIR_HOLD_POS     8
`define GPIR_WAKE_POS     4
`define GPIR_RATE_POS     4
`define GPIR_PB_POS       16
`define GPIR_DIV_BIG      4'd12
`define GPIR_DIV_W        15
`endif

/* src/gpir_pkg.sv */
// Purpose: Types of the pin interrupt router
// Assumes: Constants come from gpir_cfg.svh
// Notes:   Types only
package gpir_pkg;
  typedef logic [1:0]  gpir_sel_t;
  typedef logic [3:0]  gpir_req_t;
  typedef logic [31:0] gpir_word_t;
endpackage : gpir_pkg

/* src/gpir_strobe.sv */
// Purpose: Debounce sample strobe generator
// Assumes: Rate code 0..15, period 2**code bus clocks
// Notes:   Free running divider
`timescale 1ns/1ps
`default_nettype none
`include "gpir_cfg.svh"
module gpir_strobe #(
  parameter int W = `GPIR_DIV_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic [3:0] rate,
  output logic            strobe
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } gpir_sst_t;
  gpir_sst_t st;
  gpir_sst_t next_st;
  logic [W-1:0] mask;
  always_comb begin
    // Period 2**rate: codes 0..12 then 13..15 as 32..128 * 256
    mask    = W'((32'd1 << rate) - 32'd1);
    strobe  = ((st.cnt & mask) == '0);
    next_st = st;
    next_st.cnt = st.cnt + W'(1);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule : gpir_strobe
`default_nettype wire

/* src/gpir_router.sv */
// Purpose: Routes pin edges of three ports onto four requests
// Assumes: Pins are asynchronous; APB slave, zero wait
// Notes:   Debounce paced by pclk
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpir_cfg.svh"
module gpir_router #(
  parameter int NA = 16,
  parameter int NB = 10,
  parameter int NC = 11
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [NA-1:0] port_a_pin,
  input  wire logic [NB-1:0] port_b_pin,
  input  wire logic [NC-1:0] port_c_pin,
  output logic      [3:0]    irq_req,
  output logic               wake_req,
  output logic               pd_block,
  output logic               irq
);
  localparam int NP = NA + NB + NC;
  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    logic [NP-1:0] s1;
    logic [NP-1:0] s2;
    logic [NP-1:0] prev;
    logic [7:0]    dbc;
    logic [31:0]   grp_a;
    logic [31:0]   grp_b;
    logic [31:0]   grp_c;
    logic [31:0]   edg_a;
    logic [31:0]   edg_b;
    logic [31:0]   edg_c;
    logic [8:0]    ctrl;
    logic [NA-1:0] snap_a;
    logic [NB-1:0] snap_b;
    logic [NC-1:0] snap_c;
    logic [NP-1:0] flag;
    logic [3:0]    req;
    logic [3:0]    istat;
    logic [3:0]    imask;
    logic          pd_mode;
    logic [31:0]   rdata;
  } gpir_st_t;
  gpir_st_t st;
  gpir_st_t next_st;
  logic            strobe;
  logic [NP-1:0]   pins;
  logic [NP-1:0]   smp;
  logic [NP-1:0]   rise_en;
  logic [NP-1:0]   fall_en;
  logic [2*NP-1:0] sel;
  logic [NP-1:0]   hit;
  logic [3:0]      ev;
  logic [3:0]      lvl;
  logic            wr;
  logic            rd;
  logic            rd_setup;
  gpir_pkg::gpir_word_t wmask;
  function automatic gpir_pkg::gpir_word_t merge(
    input gpir_pkg::gpir_word_t old,
    input gpir_pkg::gpir_word_t nw,
    input gpir_pkg::gpir_word_t m
  );
    merge = (old & ~m) | (nw & m);
  endfunction : merge
  function automatic logic pin_dbc(input logic [3:0] en,
                                   input gpir_pkg::gpir_sel_t s);
    pin_dbc = en[s];
  endfunction : pin_dbc
  gpir_strobe #(.W(`GPIR_DIV_W)) u_strobe (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .rate    (st.dbc[7:4]),
    .strobe  (strobe)
  );
  assign pins    = {port_c_pin, port_b_pin, port_a_pin};
  assign sel     = {st.grp_c[2*NC-1:0], st.grp_b[2*NB-1:0],
                    st.grp_a[2*NA-1:0]};
  assign rise_en = {st.edg_c[`GPIR_RISE_POS+NC-1:`GPIR_RISE_POS],
                    st.edg_b[`GPIR_RISE_POS+NB-1:`GPIR_RISE_POS],
                    st.edg_a[`GPIR_RISE_POS+NA-1:`GPIR_RISE_POS]};
  assign fall_en = {st.edg_c[NC-1:0], st.edg_b[NB-1:0],
                    st.edg_a[NA-1:0]};
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  // Read word captured in setup, stands through the access
  assign rd_setup = psel && !penable && !pwrite;
  assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};
  // ********************************************
  // Edge detection and routing
  // ********************************************
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      logic db;
      assign db       = pin_dbc(st.dbc[3:0], sel[2*gi+1:2*gi]);
      assign smp[gi]  = (db && !strobe) ? st.prev[gi] : st.s2[gi];
      // Both enables may be set together
      assign hit[gi]  = (rise_en[gi] && smp[gi] && !st.prev[gi]) ||
                        (fall_en[gi] && !smp[gi] && st.prev[gi]);
    end
  endgenerate
  always_comb begin
    ev  = '0;
    lvl = '0;
    for (int i = 0; i < NP; i++) begin
      ev[sel[2*i+:2]]  = ev[sel[2*i+:2]] | hit[i];
      // Wake level: high when rise is enabled, alone or with fall
      lvl[sel[2*i+:2]] = lvl[sel[2*i+:2]] |
        (rise_en[i] ? st.s2[i] : (fall_en[i] && !st.s2[i]));
    end
  end
  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    logic held;
    held         = 1'b0;
    next_st      = st;
    next_st.s1   = pins;
    next_st.s2   = st.s1;
    next_st.prev = smp;
    next_st.req  = '0;
    // Flags: set wins over a write-one clear
    if (wr && paddr == `GPIR_OFF_FLAG_AB) begin
      next_st.flag[NA-1:0] = st.flag[NA-1:0] & ~pwdata[NA-1:0];
      next_st.flag[NA+NB-1:NA] = st.flag[NA+NB-1:NA] &
        ~pwdata[`GPIR_PB_POS+NB-1:`GPIR_PB_POS];
    end
    if (wr && paddr == `GPIR_OFF_FLAG_C) begin
      next_st.flag[NP-1:NA+NB] = st.flag[NP-1:NA+NB] & ~pwdata[NC-1:0];
    end
    next_st.flag = next_st.flag | hit;
    // Pulse mode or held until flags clear
    for (int r = 0; r < 4; r++) begin
      held = 1'b0;
      for (int i = 0; i < NP; i++) begin
        held = held | (next_st.flag[i] && sel[2*i+:2] == 2'(r));
      end
      next_st.req[r] = st.ctrl[`GPIR_HOLD_POS] ? held : ev[r];
    end
    if (|(ev & st.ctrl[3:0])) begin
      next_st.snap_a = st.s2[NA-1:0];
      next_st.snap_b = st.s2[NA+NB-1:NA];
      next_st.snap_c = st.s2[NP-1:NA+NB];
    end
    next_st.istat = st.istat | ev;
    // Read clears only the bits returned; later events stay
    if (rd && paddr == `GPIR_OFF_ISTAT) begin
      next_st.istat = (st.istat & ~st.rdata[3:0]) | ev;
    end
    if (wr) begin
      unique case (paddr)
        `GPIR_OFF_DBC:    next_st.dbc = 8'(merge({24'h0, st.dbc}, pwdata,
                                                 wmask));
        `GPIR_OFF_GRP_A:  next_st.grp_a = merge(st.grp_a, pwdata, wmask);
        `GPIR_OFF_GRP_B:  next_st.grp_b = merge(st.grp_b, pwdata, wmask)
                                          & 32'h000fffff;
        `GPIR_OFF_GRP_C:  next_st.grp_c = merge(st.grp_c, pwdata, wmask)
                                          & 32'h003fffff;
        `GPIR_OFF_EDGE_A: next_st.edg_a = merge(st.edg_a, pwdata, wmask);
        `GPIR_OFF_EDGE_B: next_st.edg_b = merge(st.edg_b, pwdata, wmask)
                                          & 32'h03ff03ff;
        `GPIR_OFF_EDGE_C: next_st.edg_c = merge(st.edg_c, pwdata, wmask)
                                          & 32'h07ff07ff;
        `GPIR_OFF_CTRL:   next_st.ctrl = 9'(merge({23'h0, st.ctrl},
                                                  pwdata, wmask));
        `GPIR_OFF_IMASK:  next_st.imask = pwdata[3:0];
        `GPIR_OFF_PWR:    next_st.pd_mode = pwdata[0];
        default: ;
      endcase
    end
    next_st.rdata = '0;
    if (rd_setup) begin
      unique case (paddr)
        `GPIR_OFF_DBC:     next_st.rdata = {24'h0, st.dbc};
        `GPIR_OFF_GRP_A:   next_st.rdata = st.grp_a;
        `GPIR_OFF_GRP_B:   next_st.rdata = st.grp_b;
        `GPIR_OFF_GRP_C:   next_st.rdata = st.grp_c;
        `GPIR_OFF_EDGE_A:  next_st.rdata = st.edg_a;
        `GPIR_OFF_EDGE_B:  next_st.rdata = st.edg_b;
        `GPIR_OFF_EDGE_C:  next_st.rdata = st.edg_c;
        `GPIR_OFF_CTRL:    next_st.rdata = {23'h0, st.ctrl};
        `GPIR_OFF_SNAP_A:  next_st.rdata = 32'(st.snap_a);
        `GPIR_OFF_SNAP_B:  next_st.rdata = 32'(st.snap_b);
        `GPIR_OFF_SNAP_C:  next_st.rdata = 32'(st.snap_c);
        `GPIR_OFF_FLAG_AB: next_st.rdata = 32'({st.flag[NA+NB-1:NA],
                                                st.flag[NA-1:0]});
        `GPIR_OFF_FLAG_C:  next_st.rdata = 32'(st.flag[NP-1:NA+NB]);
        `GPIR_OFF_ISTAT:   next_st.rdata = {28'h0, st.istat};
        `GPIR_OFF_IMASK:   next_st.rdata = {28'h0, st.imask};
        `GPIR_OFF_PWR:     next_st.rdata = {31'h0, st.pd_mode};
        default:           next_st.rdata = '0;
      endcase
    end else begin
      next_st.rdata = st.rdata;
    end
  end
  // ********************************************
  // Registers
  // ********************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= '0;
      st.grp_a <= `GPIR_RST_GRP_A;
      st.grp_b <= `GPIR_RST_GRP_B;
      st.grp_c <= `GPIR_RST_GRP_C;
    end else if (ce) begin
      st <= next_st;
    end
  end
  // ********************************************
  // Outputs
  // ********************************************
  assign prdata   = st.rdata;
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign irq_req  = st.req;
  assign irq      = |(st.istat & st.imask);
  // Level wake during power down, entry blocked by active level
  assign wake_req = st.pd_mode && |(lvl & st.ctrl[7:4]);
  assign pd_block = !st.pd_mode && |(lvl & st.ctrl[7:4]);
  // ********************************************
  // Checks
  // ********************************************
  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
    (ce && !st.ctrl[`GPIR_HOLD_POS] && ev[0]) |=> irq_req[0];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse missing");
  property p_pulse_one;
    @(posedge pclk) disable iff (!presetn)
    (ce && !st.ctrl[`GPIR_HOLD_POS] && !ev[1]) |=> !irq_req[1];
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("pulse too long");
  property p_flag;
    @(posedge pclk) disable iff (!presetn)
    (ce && hit[0]) |=> st.flag[0];
  endproperty
  a_flag: assert property (p_flag) else $error("flag lost");
  property p_snap;
    @(posedge pclk) disable iff (!presetn)
    (ce && (ev[2] && st.ctrl[2])) |=> (st.snap_a == $past(st.s2[NA-1:0]));
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot wrong");
  property p_nosnap;
    @(posedge pclk) disable iff (!presetn)
    (ce && !(|(ev & st.ctrl[3:0]))) |=> $stable(st.snap_b);
  endproperty
  a_nosnap: assert property (p_nosnap) else $error("snap moved");
  property p_route;
    @(posedge pclk) disable iff (!presetn)
    hit[0] |-> ev[sel[1:0]];
  endproperty
  a_route: assert property (p_route) else $error("route wrong");
  property p_dbc;
    @(posedge pclk) disable iff (!presetn)
    (st.dbc[0] && sel[1:0] == 2'd0 && !strobe) |-> smp[0] == st.prev[0];
  endproperty
  a_dbc: assert property (p_dbc) else $error("debounce leak");
  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    (st.pd_mode && st.ctrl[4] && rise_en[0] && sel[1:0] == 2'd0
     && st.s2[0]) |-> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_block;
    @(posedge pclk) disable iff (!presetn)
    (!st.pd_mode && st.ctrl[4] && rise_en[0] && sel[1:0] == 2'd0
     && st.s2[0]) |-> pd_block;
  endproperty
  a_block: assert property (p_block) else $error("entry not blocked");
  property p_nodbc;
    @(posedge pclk) disable iff (!presetn)
    (!st.dbc[0] && sel[1:0] == 2'd0) |-> smp[0] == st.s2[0];
  endproperty
  a_nodbc: assert property (p_nodbc) else $error("direct path");
  property p_rise;
    @(posedge pclk) disable iff (!presetn)
    (!st.dbc[0] && sel[1:0] == 2'd0 && rise_en[0] && st.s2[0]
     && !st.prev[0]) |-> hit[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rise missed");
  property p_fall;
    @(posedge pclk) disable iff (!presetn)
    (!st.dbc[0] && sel[1:0] == 2'd0 && fall_en[0] && !st.s2[0]
     && st.prev[0]) |-> hit[0];
  endproperty
  a_fall: assert property (p_fall) else $error("fall missed");
  property p_fast;
    @(posedge pclk) disable iff (!presetn)
    (st.dbc[7:4] == 4'h0) |-> strobe;
  endproperty
  a_fast: assert property (p_fast) else $error("rate 0 strobe");
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (ce && st.ctrl[`GPIR_HOLD_POS] && hit[NA] && sel[2*NA+:2] == 2'd1)
    |=> irq_req[1];
  endproperty
  a_hold: assert property (p_hold) else $error("no held request");
  property p_keep;
    @(posedge pclk) disable iff (!presetn)
    (ce && st.flag[3] && !(wr && paddr == `GPIR_OFF_FLAG_AB))
    |=> st.flag[3];
  endproperty
  a_keep: assert property (p_keep) else $error("flag dropped");
  property p_keep_b;
    @(posedge pclk) disable iff (!presetn)
    (ce && st.flag[NA] && !(wr && paddr == `GPIR_OFF_FLAG_AB))
    |=> st.flag[NA];
  endproperty
  a_keep_b: assert property (p_keep_b) else $error("flag b dropped");
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (ce && wr && paddr == `GPIR_OFF_FLAG_AB && pwdata[3] && !hit[3])
    |=> !st.flag[3];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_clear_b;
    @(posedge pclk) disable iff (!presetn)
    (ce && wr && paddr == `GPIR_OFF_FLAG_AB && pwdata[`GPIR_PB_POS]
     && !hit[NA]) |=> !st.flag[NA];
  endproperty
  a_clear_b: assert property (p_clear_b) else $error("flag b kept");
  property p_snap_c;
    @(posedge pclk) disable iff (!presetn)
    (ce && ev[2] && st.ctrl[2]) |=> (st.snap_c == $past(st.s2[NP-1:NA+NB]));
  endproperty
  a_snap_c: assert property (p_snap_c) else $error("snapshot c wrong");
  property p_pulse_two;
    @(posedge pclk) disable iff (!presetn)
    (ce && !st.ctrl[`GPIR_HOLD_POS] && ev[2]) |=> irq_req[2];
  endproperty
  a_pulse_two: assert property (p_pulse_two)
    else $error("pulse two missing");
endmodule : gpir_router
`default_nettype wire

/* test/gpir_partner.sv */
// Purpose: Pin drivers and interrupt controller side of the router
// Assumes: Pins change just after a rising edge of pclk
// Notes:   Counts request cycles and the gap between them
`timescale 1ns/1ps
`default_nettype none
module gpir_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  irq_req,
  output logic      [15:0] pin_a,
  output logic      [9:0]  pin_b,
  output logic      [10:0] pin_c
);
  // ************************************************
  // Pins and request monitor
  // ************************************************
  int cyc;
  int cnt  [4];
  int gap  [4];
  int last [4];
  initial begin
    pin_a = 16'h0000;
    pin_b = 10'h000;
    pin_c = 11'h000;
  end
  task set_pins(input logic [15:0] a, input logic [9:0] b,
                input logic [10:0] c);
    @(posedge pclk);
    pin_a <= a;
    pin_b <= b;
    pin_c <= c;
  endtask : set_pins
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      if (presetn === 1'b1 && irq_req[i] === 1'b1) begin
        cnt[i]  <= cnt[i] + 1;
        gap[i]  <= cyc - last[i];
        last[i] <= cyc;
      end
    end
  end
endmodule : gpir_partner
`default_nettype wire

/* test/test_gpir_router.sv */
// Purpose: Self-checking bench of the pin interrupt router
// Assumes: APB slave answers with pready, read data valid with it
// Notes:   Debounce periods measured between two request pulses
`timescale 1ns/1ps
`default_nettype none
`include "gpir_cfg.svh"
module test_gpir_router;
  // ************************************************
  // Signals and tasks
  // ************************************************
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, wake_req, pd_block, irq;
  logic [15:0] pin_a;
  logic [9:0]  pin_b;
  logic [10:0] pin_c;
  logic [3:0]  irq_req;
  int          n_fail, n_compared;
  int          codes [2] = '{5, 13};
  int          per   [2] = '{32, 8192};

  gpir_router u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_pin(pin_a), .port_b_pin(pin_b),
    .port_c_pin(pin_c), .irq_req(irq_req), .wake_req(wake_req),
    .pd_block(pd_block), .irq(irq));
  gpir_partner u_partner (.pclk(pclk), .presetn(presetn),
    .irq_req(irq_req), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c));

  task stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // Read data taken at the edge that completes the access
    rd      = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk

  task wait_req(input int i);
    int k;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (irq_req[i] !== 1'b1 && k < 40000);
    if (k >= 40000) begin
      n_fail++;
      stop_test();
    end
  endtask : wait_req

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`GPIR_OFF_GRP_A, `GPIR_RST_GRP_A);
    rchk(`GPIR_OFF_GRP_B, `GPIR_RST_GRP_B);
    rchk(`GPIR_OFF_GRP_C, `GPIR_RST_GRP_C);
    rchk(`GPIR_OFF_EDGE_A, 32'h0);
    rchk(`GPIR_OFF_SNAP_A, 32'h0);
    wr(`GPIR_OFF_SNAP_B, 32'hffffffff);
    rchk(`GPIR_OFF_SNAP_B, 32'h0);
    rchk(12'h0fc, 32'h0);
    check({31'h0, pslverr}, 32'h0);
    // Pin A3 to request 2, both edges, snapshot on request 2
    wr(`GPIR_OFF_GRP_A, 32'h00000080);
    wr(`GPIR_OFF_EDGE_A, 32'h00080008);
    wr(`GPIR_OFF_CTRL, 32'h00000004);
    u_partner.set_pins(16'h0008, 10'h000, 11'h000);
    wait_req(2);
    repeat (4) @(negedge pclk);
    check(u_partner.cnt[0] + u_partner.cnt[1] + u_partner.cnt[3], 0);
    check(u_partner.cnt[2], 1);
    rchk(`GPIR_OFF_FLAG_AB, 32'h00000008);
    rchk(`GPIR_OFF_SNAP_A, 32'h00000008);
    wr(`GPIR_OFF_FLAG_AB, 32'h00000008);
    rchk(`GPIR_OFF_FLAG_AB, 32'h0);
    u_partner.set_pins(16'h0000, 10'h000, 11'h000);
    wait_req(2);
    repeat (4) @(negedge pclk);
    check(u_partner.cnt[2], 2);
    // Held request on port B pin 0, default group 1
    wr(`GPIR_OFF_FLAG_AB, 32'hffffffff);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(`GPIR_OFF_IMASK, 32'h00000002);
    wr(`GPIR_OFF_EDGE_B, 32'h00010000);
    wr(`GPIR_OFF_CTRL, 32'h00000100);
    u_partner.set_pins(16'h0000, 10'h001, 11'h000);
    wait_req(1);
    repeat (20) @(negedge pclk);
    check({28'h0, irq_req}, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(`GPIR_OFF_FLAG_AB, 32'h00010000);
    repeat (2) @(negedge pclk);
    check({28'h0, irq_req}, 32'h0);
    rchk(`GPIR_OFF_ISTAT, 32'h6);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    // Wake level on pin A0, both edges, request 0
    wr(`GPIR_OFF_GRP_A, 32'h0);
    wr(`GPIR_OFF_EDGE_A, 32'h00010001);
    wr(`GPIR_OFF_CTRL, 32'h00000010);
    u_partner.set_pins(16'h0001, 10'h001, 11'h000);
    repeat (8) @(negedge pclk);
    check({31'h0, pd_block}, 32'h1);
    wr(`GPIR_OFF_PWR, 32'h1);
    @(negedge pclk);
    check({31'h0, wake_req}, 32'h1);
    u_partner.set_pins(16'h0000, 10'h001, 11'h000);
    repeat (8) @(negedge pclk);
    check({31'h0, wake_req}, 32'h0);
    wr(`GPIR_OFF_PWR, 32'h0);
    wr(`GPIR_OFF_CTRL, 32'h0);
    // Debounce period between two events on request 0
    for (int j = 0; j < 2; j++) begin
      wr(`GPIR_OFF_DBC, (codes[j] << `GPIR_RATE_POS) | 32'h1);
      u_partner.set_pins(16'h0001, 10'h001, 11'h000);
      wait_req(0);
      u_partner.set_pins(16'h0000, 10'h001, 11'h000);
      wait_req(0);
      @(negedge pclk);
      check(u_partner.gap[0], per[j]);
    end
    stop_test();
  end
endmodule : test_gpir_router
`default_nettype wire
